// >>> bench/isp_host_model.sv
// Serial master model for the inertial sensor port: mode 3 frames, MSB first.
// Assumes the slave shifts out on falling clock and samples on rising clock.
`timescale 1ns/1ns
module isp_host_model (
    output logic sclk, // Serial clock, idles high
    output logic cs_n, // Chip select, active low
    output logic din, // Serial data to slave
    input wire logic dout // Serial data from slave
);
    // Idle: clock parked high, slave deselected
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // One frame of nbits; hold keeps select low with half a clock of stall
    task automatic xfer(input isp_pkg::word_t tx, input int nbits, input bit hold,
                        output isp_pkg::word_t rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        din = tx[15];
        #63;
        for (int i = 0; i < nbits; i++) begin
            sclk = 1'b0;
            #62;
            sclk = 1'b1;
            rx = {rx[14:0], dout};
            #20;
            // Past the last bit the stale value is inverted, never passing for data
            din = (i < 15) ? tx[14 - i] : ~din;
            #43;
        end
        if (!hold) begin
            cs_n = 1'b1;
            #125;
        end
    endtask

    // Stray clocks and data with select high; the slave must ignore them
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            din = ~din;
            #62;
            sclk = 1'b1;
            #63;
        end
    endtask
endmodule

// >>> bench/isp_top_tb_top.sv
// Self-checking bench for the inertial sensor serial port.
// Assumes the host model drives the link; sample period shortened to 200 cycles.
`timescale 1ns/1ns
module isp_top_tb_top;
    localparam int SMP = 200; // Short sample period keeps the run brief
    localparam int LIMIT = 50000;
    logic mclk, rst, sclk, cs_n, din, dout, dout_oe, drdy;
    isp_pkg::word_t [isp_pkg::OUT_WORDS-1:0] sensor;
    int fail_count, num_checks, cyc;

    isp_top #(.SAMPLE_CYCLES(SMP)) dut_u (.MCLK(mclk), .RST(rst), .SCLK(sclk),
        .CS_N(cs_n), .DIN(din), .SENSOR_DATA(sensor), .DOUT(dout),
        .DOUT_OE(dout_oe), .DATA_READY_PULSE_PIN(drdy));
    // Released data line floats to its pull-up level, so a missing enable shows up
    isp_host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout_oe ? dout : 1'b1));

    // Core clock, 4 ns
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            results();
        end
    end

    task chk(input string what, input isp_pkg::word_t exp, input isp_pkg::word_t got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task results;
        $display("Checks made %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Pulse width and period; a fresh value must land without any command
    task t_ready;
        int n;
        @(posedge mclk);
        sensor[0] <= 16'h5A5A;
        #1;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (drdy !== 1'b1 && n < 1000) begin @(posedge mclk); #1; n++; end
            n = 0;
            while (drdy === 1'b1 && n < 100) begin @(posedge mclk); #1; n++; end
            chk("ready width", 16'(isp_pkg::DRDY_CYCLES), 16'(n));
            while (drdy !== 1'b1 && n < 1000) begin @(posedge mclk); #1; n++; end
            chk("sample period", 16'(SMP), 16'(n));
        end
    endtask

    // Pipelined reads of all outputs, odd and even byte addresses mixed
    task t_read;
        isp_pkg::word_t rx;
        host_u.xfer(16'h0400, 16, 1'b0, rx);
        for (int i = 0; i < isp_pkg::OUT_WORDS; i++) begin
            host_u.xfer(16'((2 * i + 6 + (i % 2)) << 8), 16, 1'b0, rx);
            chk("read word", sensor[i], rx);
        end
    endtask

    // Byte writes to a config word, then a refused write to an output word
    task t_write;
        isp_pkg::word_t rx;
        host_u.xfer(16'hB703, 16, 1'b0, rx);
        host_u.xfer(16'hB6AA, 16, 1'b0, rx);
        chk("reply after write", 16'h0000, rx);
        host_u.xfer(16'h8455, 16, 1'b0, rx);
        host_u.xfer(16'h3600, 16, 1'b0, rx);
        host_u.xfer(16'h0400, 16, 1'b0, rx);
        chk("config word", 16'h03AA, rx);
        host_u.xfer(16'h0000, 16, 1'b0, rx);
        chk("output word kept", sensor[0], rx);
    endtask

    // Burst within one select, half a clock of stall between words
    task t_burst;
        isp_pkg::word_t rx;
        host_u.xfer(isp_pkg::BURST_CMD, 16, 1'b1, rx);
        for (int i = 0; i < isp_pkg::OUT_WORDS; i++) begin
            host_u.xfer(16'h0400, 16, 1'b1, rx);
            chk("burst word", sensor[i], rx);
        end
        host_u.xfer(16'h0000, 16, 1'b0, rx);
        chk("after burst", 16'h0000, rx);
    endtask

    // Partial frame dropped by deselect; next frame must start aligned
    task t_cs;
        isp_pkg::word_t rx;
        host_u.xfer(16'hFFFF, 5, 1'b0, rx);
        chk("output enable idle", 16'h0000, 16'(dout_oe));
        host_u.idle_clocks(3);
        chk("enable with stray clocks", 16'h0000, 16'(dout_oe));
        host_u.xfer(16'h0800, 16, 1'b0, rx);
        host_u.xfer(16'h0000, 16, 1'b0, rx);
        chk("realigned read", sensor[2], rx);
    endtask

    initial begin
        rst = 1'b1;
        for (int i = 0; i < isp_pkg::OUT_WORDS; i++) begin
            sensor[i] = 16'hA0C1 + 16'(i) * 16'h0123;
        end
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        t_ready();
        t_read();
        t_write();
        t_burst();
        t_cs();
        results();
    end
endmodule

// >>> verilog/isp_link.sv
// Serial clock side of the port: frame shifters for both data lines.
// Assumes clock idles high; chip select high clears the frame logic at once.
`timescale 1ns/1ns
module isp_link (
    input wire logic sclk, // Serial clock from master
    input wire logic rst, // Core reset, used asynchronously here
    input wire logic cs_n, // Chip select, active low
    input wire logic din, // Serial data in
    input wire isp_pkg::word_t tx_word, // Reply word, held steady by core
    output isp_pkg::word_t rx_word, // Last complete frame
    output logic rx_toggle, // Flips once per complete frame
    output logic dout, // Serial data out
    output logic dout_oe // Data out drive enable
);
    logic [isp_pkg::BIT_CNT_W-1:0] rx_cnt;
    logic [14:0] rx_shift;
    logic [isp_pkg::BIT_CNT_W-1:0] tx_cnt;
    isp_pkg::word_t tx_shift;
    wire tx_msb = tx_word[15];

    // Rising edge capture; idle select holds counter at frame start
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rx_cnt <= isp_pkg::FIRST_BIT;
            rx_shift <= 15'h0000;
        end else begin
            rx_cnt <= rx_cnt + 4'h1;
            rx_shift <= {rx_shift[13:0], din};
        end
    end

    // Frame hand-off; word stays put for a whole frame so core can read it
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rx_word <= isp_pkg::WORD_RESET;
            rx_toggle <= 1'b0;
        end else if (rx_cnt == isp_pkg::LAST_BIT) begin
            rx_word <= {rx_shift, din};
            rx_toggle <= ~rx_toggle;
        end
    end

    // Falling edge launch; first fall loads the whole reply word
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_cnt <= isp_pkg::FIRST_BIT;
            tx_shift <= isp_pkg::WORD_RESET;
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= 1'b1;
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == isp_pkg::FIRST_BIT) begin
                tx_shift <= tx_word;
            end else begin
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    assign dout = tx_shift[15];

    property p_rx_frame;
        @(posedge sclk) disable iff (cs_n || rst)
        rx_cnt == isp_pkg::LAST_BIT |=> rx_toggle != $past(rx_toggle);
    endproperty
    a_rx_frame: assert property (p_rx_frame) else $error("frame end not signalled");

    property p_tx_load;
        @(negedge sclk) disable iff (cs_n || rst)
        tx_cnt == isp_pkg::FIRST_BIT |=> dout == $past(tx_msb) && dout_oe;
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("reply msb not launched");
endmodule

// >>> verilog/isp_pkg.sv
// Constants and types shared by the inertial sensor serial port.
// Assumes a 250 MHz core clock and a serial master that idles its clock high.
package isp_pkg;
    // Register word and byte addressing
    typedef logic [15:0] word_t;
    localparam int REG_WORDS = 64;
    localparam int WIDX_W = 6;
    localparam logic [5:0] OUT_FIRST_WORD = 6'h02;
    localparam int OUT_WORDS = 7;
    localparam logic [5:0] OUT_LAST_WORD = OUT_FIRST_WORD + 6'(OUT_WORDS - 1);
    localparam word_t WORD_RESET = 16'h0000;
    localparam word_t REPLY_UNDEFINED = 16'h0000;

    // Command words
    localparam word_t BURST_CMD = 16'h3E00;

    // Frame bit counting
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] FIRST_BIT = 4'h0;
    localparam logic [3:0] LAST_BIT = 4'hF;

    // Sample timing: rate held in milli-samples per second
    localparam longint MCLK_HZ = 250000000;
    localparam longint SAMPLE_RATE_MSPS = 819200;
    localparam int SAMPLE_CYCLES = int'((MCLK_HZ * 1000) / SAMPLE_RATE_MSPS);
    localparam int MCLK_PERIOD_NS = 4;
    localparam int DRDY_TIME_NS = 100;
    localparam int DRDY_CYCLES = (DRDY_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int DRDY_CNT_W = 6;

    // One received frame as the decoder sees it
    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } cmd_t;
endpackage

// >>> verilog/isp_top.sv
// Serial slave port of a six-axis inertial module with its register words.
// Assumes sensing logic on MCLK presents fresh results on SENSOR_DATA.
// Behaviour
// - Each word reachable as two byte addresses
// - Port acts only while select is low
// - Command bits captured on rising clock
// - Reply bits launched on falling clock
// - Reply carries data asked by earlier command
// - Samples update autonomously, always readable
// - Sixteen-bit frames; reply in next frame
// - Command 3E00 streams all outputs in order
// - Top bit set writes one byte of a non-output word; output words refuse writes
// - Sample at 819.2 SPS, pulse ready
`timescale 1ns/1ns
module isp_top #(
    parameter int SAMPLE_CYCLES = isp_pkg::SAMPLE_CYCLES
) (
    input wire logic MCLK, // Core clock
    input wire logic RST, // Reset, active high; synchronous on MCLK, asynchronous in the link
    input wire logic SCLK, // Serial clock from master
    input wire logic CS_N, // Chip select, active low
    input wire logic DIN, // Serial data in
    input wire isp_pkg::word_t [isp_pkg::OUT_WORDS-1:0] SENSOR_DATA, // Fresh results
    output logic DOUT, // Serial data out
    output logic DOUT_OE, // High while DOUT is driven
    output logic DATA_READY_PULSE_PIN // Pulse after each sample
);
    localparam int CNT_W = $clog2(SAMPLE_CYCLES);

    isp_pkg::word_t regs [isp_pkg::REG_WORDS];
    isp_pkg::word_t rx_word;
    isp_pkg::word_t tx_word;
    logic rx_toggle;
    logic tog_meta;
    logic tog_sync;
    logic tog_prev;
    logic cs_meta;
    logic cs_sync;
    logic burst_active;
    logic [isp_pkg::WIDX_W-1:0] burst_idx;
    logic [CNT_W-1:0] sample_cnt;
    logic [isp_pkg::DRDY_CNT_W-1:0] drdy_cnt;

    // Link side shifters on the serial clock
    isp_link u_link (
        .sclk(SCLK),
        .rst(RST),
        .cs_n(CS_N),
        .din(DIN),
        .tx_word(tx_word),
        .rx_word(rx_word),
        .rx_toggle(rx_toggle),
        .dout(DOUT),
        .dout_oe(DOUT_OE)
    );

    // Frame event and select cross by two flops each
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_prev <= 1'b0;
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
        end else begin
            tog_meta <= rx_toggle;
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
            cs_meta <= CS_N;
            cs_sync <= cs_meta;
        end
    end

    // Command decode; word is stable for a frame after its toggle
    isp_pkg::cmd_t cmd;
    wire rx_evt = tog_sync ^ tog_prev;
    assign cmd = isp_pkg::cmd_t'(rx_word);
    wire [isp_pkg::WIDX_W-1:0] widx = cmd.addr[6:1];
    wire upper_byte = cmd.addr[0];
    wire is_burst = rx_word == isp_pkg::BURST_CMD;
    wire in_out = widx >= isp_pkg::OUT_FIRST_WORD && widx <= isp_pkg::OUT_LAST_WORD;
    wire burst_step = rx_evt && burst_active;
    wire burst_done = burst_step && burst_idx == isp_pkg::OUT_LAST_WORD;
    wire start_burst = rx_evt && !burst_active && is_burst;
    wire write_req = rx_evt && !burst_active && cmd.write;
    wire read_req = rx_evt && !burst_active && !cmd.write && !is_burst;
    wire tick = sample_cnt == CNT_W'(SAMPLE_CYCLES - 1);

    // Reply selection for the next frame
    isp_pkg::word_t rd_word;
    isp_pkg::word_t burst_next_word;
    isp_pkg::word_t next_tx_word;
    assign rd_word = regs[widx];
    assign burst_next_word = regs[burst_idx + 6'h01];
    assign next_tx_word = start_burst ? regs[isp_pkg::OUT_FIRST_WORD] :
                          burst_done ? isp_pkg::REPLY_UNDEFINED :
                          burst_step ? burst_next_word :
                          read_req ? rd_word :
                          write_req ? isp_pkg::REPLY_UNDEFINED : tx_word;

    // Reply word and burst walk; select release ends a burst
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tx_word <= isp_pkg::REPLY_UNDEFINED;
            burst_active <= 1'b0;
            burst_idx <= isp_pkg::OUT_FIRST_WORD;
        end else begin
            tx_word <= next_tx_word;
            if (cs_sync || burst_done) begin
                burst_active <= 1'b0;
            end else if (start_burst) begin
                burst_active <= 1'b1;
                burst_idx <= isp_pkg::OUT_FIRST_WORD;
            end else if (burst_step) begin
                burst_idx <= burst_idx + 6'h01;
            end
        end
    end

    // Register words; outputs follow the sampler, the rest take byte writes
    for (genvar g = 0; g < isp_pkg::REG_WORDS; g++) begin : g_reg
        if (g >= isp_pkg::OUT_FIRST_WORD && g <= isp_pkg::OUT_LAST_WORD) begin : g_out
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    regs[g] <= isp_pkg::WORD_RESET;
                end else if (tick) begin
                    regs[g] <= SENSOR_DATA[g - isp_pkg::OUT_FIRST_WORD];
                end
            end
        end else begin : g_cfg
            wire hit = write_req && widx == 6'(g);
            always_ff @(posedge MCLK) begin
                if (RST) begin
                    regs[g] <= isp_pkg::WORD_RESET;
                end else if (hit && upper_byte) begin
                    regs[g][15:8] <= cmd.data;
                end else if (hit) begin
                    regs[g][7:0] <= cmd.data;
                end
            end
        end
    end

    // Free-running sample timer, independent of the master
    always_ff @(posedge MCLK) begin
        if (RST || tick) begin
            sample_cnt <= '0;
        end else begin
            sample_cnt <= sample_cnt + 1'b1;
        end
    end

    // Data ready pulse; fixed width so slow hosts still see it
    always_ff @(posedge MCLK) begin
        if (RST) begin
            drdy_cnt <= '0;
            DATA_READY_PULSE_PIN <= 1'b0;
        end else begin
            DATA_READY_PULSE_PIN <= tick || drdy_cnt > 6'h01;
            if (tick) begin
                drdy_cnt <= 6'(isp_pkg::DRDY_CYCLES);
            end else if (drdy_cnt != 6'h00) begin
                drdy_cnt <= drdy_cnt - 6'h01;
            end
        end
    end

    property p_drdy_pulse;
        @(posedge MCLK) disable iff (RST)
        tick |=> DATA_READY_PULSE_PIN ##25 !DATA_READY_PULSE_PIN;
    endproperty
    a_drdy_pulse: assert property (p_drdy_pulse) else $error("ready pulse wrong");

    property p_sample_load;
        @(posedge MCLK) disable iff (RST)
        tick |=> regs[isp_pkg::OUT_FIRST_WORD] == $past(SENSOR_DATA[0]);
    endproperty
    a_sample_load: assert property (p_sample_load) else $error("sample not loaded");

    property p_read_reply;
        @(posedge MCLK) disable iff (RST)
        read_req |=> tx_word == $past(rd_word);
    endproperty
    a_read_reply: assert property (p_read_reply) else $error("reply not requested word");

    property p_write_byte;
        @(posedge MCLK) disable iff (RST)
        write_req && !in_out |=> (upper_byte ? rd_word[15:8] : rd_word[7:0]) == $past(cmd.data);
    endproperty
    a_write_byte: assert property (p_write_byte) else $error("byte not written");

    property p_burst_start;
        @(posedge MCLK) disable iff (RST)
        start_burst && !cs_sync |=> burst_active && tx_word == $past(regs[isp_pkg::OUT_FIRST_WORD]);
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("burst not started");

    property p_burst_step;
        @(posedge MCLK) disable iff (RST)
        burst_step && !burst_done |=> tx_word == $past(burst_next_word);
    endproperty
    a_burst_step: assert property (p_burst_step) else $error("burst order broken");

    property p_release;
        @(posedge MCLK) disable iff (RST)
        cs_sync |-> !DOUT_OE;
    endproperty
    a_release: assert property (p_release) else $error("output driven while idle");

    // A sample load in the same cycle may still change the word
    property p_write_refused;
        @(posedge MCLK) disable iff (RST)
        write_req && in_out && !tick |=> rd_word == $past(rd_word);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("output word written");

    property p_burst_range;
        @(posedge MCLK) disable iff (RST)
        burst_active |->
            burst_idx >= isp_pkg::OUT_FIRST_WORD && burst_idx <= isp_pkg::OUT_LAST_WORD;
    endproperty
    a_burst_range: assert property (p_burst_range) else $error("burst index out of range");

    c_burst: cover property (@(posedge MCLK) disable iff (RST) burst_done);
    c_write: cover property (@(posedge MCLK) disable iff (RST) write_req);
    c_read: cover property (@(posedge MCLK) disable iff (RST) read_req ##[1:1000] read_req);
    c_ready: cover property (@(posedge MCLK) disable iff (RST) tick ##1 DATA_READY_PULSE_PIN);
endmodule
